// ===== verilog/octal_switch_map.vh
// constants for the octal switch serial control port
// included by the switch control design file
`ifndef OCTAL_SWITCH_MAP_VH
`define OCTAL_SWITCH_MAP_VH
`define FRAME_BITS        8
`define LATCH_RESET       8'h00
`define STATUS_IDLE       8'h00
`define OUT_FIVE_BIT      4
`define OUT_SIX_BIT       5
`define FAULT_TIME_US     300
`define CLOCK_MHZ         40
`define FAULT_CYCLES      (`FAULT_TIME_US * `CLOCK_MHZ)
`endif

// ===== verilog/pin_sync.v
// two-flop synchroniser plus edge detect for a group of pins
// assumes pins are asynchronous to clock
`timescale 1ns/1ps
`default_nettype none
module pin_sync #(
   parameter WIDTH = 3
) (
   input  wire             clock,
   input  wire             rst_n,
   input  wire [WIDTH-1:0] pin_in,
   output reg  [WIDTH-1:0] level,
   output wire [WIDTH-1:0] rise,
   output wire [WIDTH-1:0] fall
);
   reg [WIDTH-1:0] meta_reg;
   reg [WIDTH-1:0] prev_reg;
   genvar i;
   generate
      for (i = 0; i < WIDTH; i = i + 1) begin : g_bit
         always @(posedge clock or negedge rst_n) begin
            if (!rst_n) begin
               meta_reg[i] <= 1'b0;
               level[i]    <= 1'b0;
               prev_reg[i] <= 1'b0;
            end else begin
               meta_reg[i] <= pin_in[i];
               level[i]    <= meta_reg[i];
               prev_reg[i] <= level[i];
            end
         end
         assign rise[i] = level[i] & ~prev_reg[i];
         assign fall[i] = ~level[i] & prev_reg[i];
      end
   endgenerate
endmodule // pin_sync
`default_nettype wire

// ===== verilog/octal_switch_serial_control.v
// serial control and fault report port of an eight-output power switch
// assumes clock is much faster than sclk; all pins are asynchronous
// Functional notes
// - chip select rising edge copies shift register into output latch.
// - chip select falling edge loads fault status into shift register.
// - serial_out driven only while chip select is low.
// - serial_in sampled on sclk falling edge while selected.
// - serial_out takes next shift bit on sclk rising edge.
// - sclk and serial_in ignored while chip select high.
// - eight-bit shift register, eight bits per frame.
// - bits go most significant first, output 8 down to 1.
// - one turns output on, zero off, at chip select rise.
// - status bit one means fault, zero means normal.
// - first sclk rise shows output 8 status, then descending.
// - shift register is first-in first-out for daisy chaining.
// - enable low blocks output drive and fault reporting.
// - latched outputs return when enable goes high again.
// - outputs five and six ORed with direct drive inputs.
`timescale 1ns/1ps
`default_nettype none
`include "octal_switch_map.vh"
module octal_switch_serial_control #(
   parameter WIDTH = `FRAME_BITS
) (
   input  wire             clock,
   input  wire             rst_n,
   input  wire             chip_select_n,
   input  wire             sclk,
   input  wire             serial_in,
   output reg              serial_out,
   output reg              serial_out_oe,
   input  wire             enable,
   input  wire             direct_drive_five,
   input  wire             direct_drive_six,
   input  wire [WIDTH-1:0] fault_sense,
   output reg  [WIDTH-1:0] gate_drive,
   output reg  [WIDTH-1:0] command_latch
);
   // one-hot frame states
   localparam [1:0] ST_IDLE  = 2'b01;
   localparam [1:0] ST_FRAME = 2'b10;

   wire [2:0]       lvl;
   wire [2:0]       rise;
   wire [2:0]       fall;
   wire             selected;
   wire             select_start;
   wire             select_end;
   wire             sclk_rise;
   wire             sclk_fall;
   wire             enabled;
   reg              enable_meta_reg;
   reg              enable_reg;
   reg  [WIDTH-1:0] fault_meta_reg;
   reg  [WIDTH-1:0] fault_reg;
   reg  [WIDTH-1:0] shift_reg;
   reg  [WIDTH-1:0] shift_next;
   reg  [1:0]       state_reg;
   reg  [1:0]       state_next;

   // chip select is inverted ahead of the flops so that the reset value
   // means deselected; no false select edge follows reset
   // index 0 selected, 1 sclk, 2 serial_in
   pin_sync #(.WIDTH(3)) u_sync (
      .clock  (clock),
      .rst_n  (rst_n),
      .pin_in ({serial_in, sclk, ~chip_select_n}),
      .level  (lvl),
      .rise   (rise),
      .fall   (fall)
   );

   assign selected     = lvl[0];
   assign select_start = rise[0];
   assign select_end   = fall[0];
   assign sclk_rise    = rise[1];
   assign sclk_fall    = fall[1];
   assign enabled      = enable_reg;

   // enable passes two flops
   always @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         enable_meta_reg <= 1'b0;
         enable_reg      <= 1'b0;
      end else begin
         enable_meta_reg <= enable;
         enable_reg      <= enable_meta_reg;
      end
   end

   // fault levels pass two flops; bits are independent slow levels, so a
   // bit caught mid-change only moves its report to the next frame
   always @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         fault_meta_reg <= `STATUS_IDLE;
         fault_reg      <= `STATUS_IDLE;
      end else begin
         fault_meta_reg <= fault_sense;
         fault_reg      <= fault_meta_reg;
      end
   end

   reg [1:0] dd_meta_reg;
   reg [1:0] dd_reg;
   always @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         dd_meta_reg <= 2'h0;
         dd_reg      <= 2'h0;
      end else begin
         dd_meta_reg <= {direct_drive_six, direct_drive_five};
         dd_reg      <= dd_meta_reg;
      end
   end

   // frame state; select edges come from one synchroniser, so they
   // always alternate and a start and an end never share one cycle
   always @* begin
      state_next = state_reg;
      case (state_reg)
         ST_IDLE: begin
            if (select_start)
               state_next = ST_FRAME;
         end
         ST_FRAME: begin
            if (select_end)
               state_next = ST_IDLE;
         end
         default: begin
            state_next = ST_IDLE;
         end
      endcase
   end

   always @* begin
      shift_next = shift_reg;
      if (select_start)
         shift_next = enabled ? fault_reg : `STATUS_IDLE;
      else if (state_reg == ST_FRAME && selected && sclk_fall)
         shift_next = {shift_reg[WIDTH-2:0], lvl[2]};
   end

   always @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         state_reg <= ST_IDLE;
         shift_reg <= `STATUS_IDLE;
      end else begin
         state_reg <= state_next;
         shift_reg <= shift_next;
      end
   end

   // cleared at select so the host never sees a stale bit before sclk
   always @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         serial_out <= 1'b0;
      end else if (select_start) begin
         serial_out <= 1'b0;
      end else if (state_reg == ST_FRAME && selected && sclk_rise) begin
         serial_out <= shift_reg[WIDTH-1];
      end
   end

   // driven only when selected
   // enable lags the pin by the synchroniser, about three clocks
   always @(posedge clock or negedge rst_n) begin
      if (!rst_n)
         serial_out_oe <= 1'b0;
      else
         serial_out_oe <= selected;
   end

   // last eight bits win; reset clears
   always @(posedge clock or negedge rst_n) begin
      if (!rst_n)
         command_latch <= `LATCH_RESET;
      else if (select_end)
         command_latch <= shift_reg;
   end

   genvar k;
   generate
      for (k = 0; k < WIDTH; k = k + 1) begin : g_out
         wire direct_on;
         if (k == `OUT_FIVE_BIT) begin : g_five
            assign direct_on = dd_reg[0];
         end else if (k == `OUT_SIX_BIT) begin : g_six
            assign direct_on = dd_reg[1];
         end else begin : g_none
            assign direct_on = 1'b0;
         end
         always @(posedge clock or negedge rst_n) begin
            if (!rst_n)
               gate_drive[k] <= 1'b0;
            else
               gate_drive[k] <= enabled & (command_latch[k] | direct_on);
         end
      end
   endgenerate

   // enable never touches the latch, so commanded outputs come back on
   // by themselves when enable returns
endmodule // octal_switch_serial_control
`default_nettype wire

// ===== bench/switch_monitor.sv
// pin-level checks for the octal switch serial control port
// bound to the design top; sees only its ports
`timescale 1ns/1ps
`default_nettype none
module switch_monitor #(
   parameter WIDTH = 8
) (
   input wire logic             clock,
   input wire logic             rst_n,
   input wire logic             chip_select_n,
   input wire logic             sclk,
   input wire logic             enable,
   input wire logic             direct_drive_five,
   input wire logic             direct_drive_six,
   input wire logic             serial_out,
   input wire logic             serial_out_oe,
   input wire logic [WIDTH-1:0] command_latch,
   input wire logic [WIDTH-1:0] gate_drive
);
   default clocking @(posedge clock); endclocking
   default disable iff (!rst_n);
   // six cycles covers the two sync flops and the edge detect
   a_oe_idle_off:
      assert property (chip_select_n [*6] |-> !serial_out_oe) else $error("oe while idle");
   a_oe_sel_on:
      assert property (!chip_select_n [*6] |-> serial_out_oe) else $error("oe off while selected");
   a_latch_idle_hold:
      assert property (chip_select_n [*6] |=> $stable(command_latch)) else $error("latch moved");
   a_latch_on_rise:
      assert property ($changed(command_latch) |-> chip_select_n && $past(chip_select_n, 2))
      else $error("latch change without cs rise");
   a_out_sclk_low:
      assert property ((!chip_select_n && !sclk) [*6] |=> $stable(serial_out)) else $error("so moved");
   a_gate_disabled:
      assert property (!enable [*6] |-> gate_drive == 8'h00) else $error("gate while disabled");
   a_gate_or_direct:
      assert property ((enable && $stable(command_latch)
         && $stable({direct_drive_six, direct_drive_five})) [*6] |-> gate_drive ==
         (command_latch | {2'h0, direct_drive_six, direct_drive_five, 4'h0}))
      else $error("gate mismatch");
   a_reset_clear:
      assert property (disable iff (1'b0) !rst_n [*2] |-> command_latch == 8'h00)
      else $error("no clear");
   c_select: cover property ($rose(serial_out_oe));
   c_direct: cover property ($rose(gate_drive[4]));
   c_disable: cover property ($fell(enable));
endmodule // switch_monitor
bind octal_switch_serial_control switch_monitor #(.WIDTH(WIDTH)) u_mon (.*);
`default_nettype wire

// ===== bench/spi_master_model.sv
// host-side serial master for the switch control port
// paced by the design clock; sclk period is eight clocks (200 ns)
`timescale 1ns/1ps
`default_nettype none
module spi_master_model (
   input wire logic  clock,
   input wire logic  serial_out,
   output var logic  chip_select_n,
   output var logic  sclk,
   output var logic  serial_in
);
   // accesses over 300 us apart at a 25 ns clock
   localparam int ACCESS_GAP = 12001;
   initial begin
      chip_select_n = 1'b1;
      sclk = 1'b0;
      serial_in = 1'b0;
   end
   // msb first, sclk low at cs edges
   task automatic xfer(input logic [15:0] tx, input int n, output logic [15:0] rx);
      rx = 16'h0000;
      @(negedge clock) chip_select_n = 1'b0;
      repeat (6) @(negedge clock);
      for (int i = n - 1; i >= 0; i--) begin
         sclk = 1'b1;
         serial_in = tx[i];
         repeat (4) @(negedge clock);
         rx = {rx[14:0], serial_out};
         sclk = 1'b0;
         repeat (4) @(negedge clock);
      end
      chip_select_n = 1'b1;
      // released data line must not look like a held bit
      serial_in = ~serial_in;
      repeat (ACCESS_GAP) @(negedge clock);
   endtask
endmodule // spi_master_model
`default_nettype wire

// ===== bench/testbench.sv
// self-checking bench for the octal switch serial control port
// master model drives the pins; bench drives enable, direct inputs, faults
`timescale 1ns/1ps
`default_nettype none
module testbench;
   logic clock = 0, rst_n = 0, enable = 0, dd5 = 0, dd6 = 0;
   logic cs_n, sclk, si, so, oe;
   logic [7:0] fault = 8'hA5, gate, latch;
   logic [15:0] rx;
   int err_count = 0, compares = 0, cycles = 0;
   always #12.5 clock = ~clock;
   octal_switch_serial_control u_dut (.clock(clock), .rst_n(rst_n), .chip_select_n(cs_n),
      .sclk(sclk), .serial_in(si), .serial_out(so), .serial_out_oe(oe), .enable(enable),
      .direct_drive_five(dd5), .direct_drive_six(dd6), .fault_sense(fault),
      .gate_drive(gate), .command_latch(latch));
   spi_master_model u_host (.clock(clock), .serial_out(so), .chip_select_n(cs_n),
      .sclk(sclk), .serial_in(si));
   task automatic chk(input logic [15:0] got, input logic [15:0] exp);
      compares++;
      if (got !== exp) begin
         err_count++;
         $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task automatic give_verdict;
      $display("errors=%0d compares=%0d", err_count, compares);
      if (err_count == 0 && compares > 0) $display("TEST PASSED");
      else $display("TEST FAILED");
      $finish;
   endtask
   task automatic idle(input int n);
      repeat (n) @(negedge clock);
   endtask
   always @(posedge clock) begin
      cycles++;
      if (cycles > 60000) begin
         err_count++;
         give_verdict;
      end
   end
   initial begin
      idle(8);
      rst_n = 1;
      enable = 1;
      idle(4);
      u_host.xfer(16'h00C3, 8, rx);
      chk(rx, 16'h00A5);
      chk(latch, 8'hC3);
      chk(gate, 8'hC3);
      fault = 8'h18;
      u_host.xfer(16'h5A0C, 16, rx);
      chk(rx, 16'h185A);
      chk(latch, 8'h0C);
      // command bits five and six off, static direct level
      dd5 = 1;
      idle(8);
      chk(gate, 8'h1C);
      dd5 = 0;
      dd6 = 1;
      idle(8);
      chk(gate, 8'h2C);
      enable = 0;
      idle(8);
      chk(gate, 8'h00);
      enable = 1;
      idle(8);
      chk(gate, 8'h2C);
      dd6 = 0;
      enable = 0;
      u_host.xfer(16'h0033, 8, rx);
      chk(rx, 16'h0000);
      chk(latch, 8'h33);
      enable = 1;
      idle(8);
      chk(gate, 8'h33);
      rst_n = 0;
      idle(2);
      chk(latch, 8'h00);
      chk(gate, 8'h00);
      rst_n = 1;
      idle(4);
      chk(latch, 8'h00);
      u_host.xfer(16'h0081, 8, rx);
      chk(rx, 16'h0018);
      chk(latch, 8'h81);
      give_verdict;
   end
endmodule // testbench
`default_nettype wire
